// ---- rtl/vic_pkg.sv ----
// Constants shared by the vectored interrupt unit
package vic_pkg;
	localparam int NUM_CHAN = 19;
	localparam int CHAN_W   = 5;
	localparam int NUM_SLOT = 16;
	localparam int SLOT_W   = 4;
	localparam int ADDR_W   = 8;
	localparam int DATA_W   = 32;
	// Channel assignment
	localparam int CH_WDOG  = 0;
	localparam int CH_SOFT  = 1;
	localparam int CH_DBGRX = 2;
	localparam int CH_DBGTX = 3;
	localparam int CH_TMR0  = 4;
	localparam int CH_TMR1  = 5;
	localparam int CH_SER0  = 6;
	localparam int CH_SER1  = 7;
	localparam int CH_PWM   = 8;
	localparam int CH_TWI   = 9;
	localparam int CH_SPI0  = 10;
	localparam int CH_SPI1  = 11;
	localparam int CH_PLL   = 12;
	localparam int CH_RTC   = 13;
	localparam int CH_EXT0  = 14;
	localparam int CH_ADC   = 18;
	localparam int NUM_EXT  = 4;
	localparam int NUM_TMRM = 4;
	localparam int NUM_PWMM = 7;
	// Register offsets
	localparam logic [7:0] OFF_VECT    = 8'h00;
	localparam logic [7:0] OFF_RAW     = 8'h04;
	localparam logic [7:0] OFF_ENABLE  = 8'h08;
	localparam logic [7:0] OFF_VENA    = 8'h0c;
	localparam logic [7:0] OFF_SOFT    = 8'h10;
	localparam logic [7:0] OFF_SOFTCLR = 8'h14;
	localparam logic [7:0] OFF_DEFADDR = 8'h18;
	localparam logic [7:0] OFF_IRQSTAT = 8'h1c;
	localparam logic [7:0] OFF_NVSTAT  = 8'h20;
	localparam logic [7:0] OFF_EVSTAT  = 8'h24;
	localparam logic [7:0] OFF_EVENA   = 8'h28;
	localparam logic [7:0] OFF_EVCLR   = 8'h2c;
	localparam logic [7:0] OFF_VADDR0  = 8'h40;
	localparam logic [7:0] OFF_VCTRL0  = 8'h80;
	localparam logic [7:0] SLOT_MASK   = 8'hc0;
	localparam logic [7:0] SLOT_SHIFT  = 8'h02;
	// Vector control fields: channel in low bits, slot enable above
	localparam int VCTRL_EN_BIT = 5;
	localparam logic [5:0] VCTRL_RESET = 6'h00;
	localparam logic [31:0] DEFADDR_RESET = 32'h0000_0000;
	// Interrupt event bits
	localparam int EV_VECT  = 0;
	localparam int EV_NVEC  = 1;
	localparam int NUM_EV   = 2;
endpackage

// ---- rtl/vic_prio.sv ----
`timescale 1ns/1ps
// Fixed priority pick: lowest slot index wins
module vic_prio #(
	parameter int N  = vic_pkg::NUM_SLOT,
	parameter int IW = vic_pkg::SLOT_W
) (
	input  wire logic [N-1:0]  req,
	output logic               any,
	output logic      [IW-1:0] idx
);
	// Elaboration check: the index must reach every slot
	if (N > (1 << IW)) begin : g_bad_width
		$error("vic_prio: index too narrow");
	end

	assign any = |req;

	always_comb begin
		idx = '0;
		for (int i = N - 1; i >= 0; i--) begin
			if (req[i])
				idx = IW'(i);
		end
	end
endmodule

// ---- rtl/vic_slot.sv ----
`timescale 1ns/1ps
// One priority slot: vector address and channel select
module vic_slot #(
	parameter int NCH = vic_pkg::NUM_CHAN
) (
	input  wire logic                      sys_clk,
	input  wire logic                      resetn,
	input  wire logic                      clk_en,
	input  wire logic                      wr_addr,
	input  wire logic                      wr_ctrl,
	input  wire logic [vic_pkg::DATA_W-1:0] wdata,
	input  wire logic [NCH-1:0]            active,
	output logic      [vic_pkg::DATA_W-1:0] vaddr_reg,
	output logic      [5:0]                vctrl_reg,
	output logic                           hit
);
	wire logic [vic_pkg::CHAN_W-1:0] chan = vctrl_reg[vic_pkg::CHAN_W-1:0];
	wire logic                       valid_chan = (32'(chan) < NCH);

	assign hit = vctrl_reg[vic_pkg::VCTRL_EN_BIT] && valid_chan && active[chan];

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			vaddr_reg <= '0;
			vctrl_reg <= vic_pkg::VCTRL_RESET;
		end else if (clk_en) begin
			if (wr_addr)
				vaddr_reg <= wdata;
			if (wr_ctrl)
				vctrl_reg <= wdata[5:0];
		end
	end
endmodule

// ---- rtl/vic_top.sv ----
`timescale 1ns/1ps
// Vectored interrupt unit: channel mapping, priority, vector and status registers
// Operation
// - Non-vectored requests rank below all vectored
// - All pending requests merge into one IRQ
// - Vector read returns highest-priority vectored address
// - No vectored pending returns shared default address
// - Second register shows raw requests before enable masking
// - Each peripheral drives one combined request line
// - Channel 0 watchdog, channel 1 software only
// - Ch 2/3 debug, ch 4/5 timer matches
// - Channel 6 first serial port flags
// - Channel 7 second serial port plus modem
// - Channel 8 modulator matches zero to six
// - Ch 9 two-wire, 10/11 serial-peripheral flags
// - Ch 12 lock flag, 13 clock flags
// - Ch 14-17 external, 18 converter
module vic_top #(
	parameter int NSLOT = vic_pkg::NUM_SLOT
) (
	input  wire logic                        sys_clk,
	input  wire logic                        resetn,
	input  wire logic                        clk_en,
	input  wire logic [vic_pkg::ADDR_W-1:0]  reg_addr,
	input  wire logic [vic_pkg::DATA_W-1:0]  reg_wdata,
	input  wire logic                        reg_wr,
	input  wire logic                        reg_rd,
	output logic      [vic_pkg::DATA_W-1:0]  reg_rdata,
	input  wire logic                        watchdog_flag,
	input  wire logic                        debug_comm_receive,
	input  wire logic                        debug_comm_transmit,
	input  wire logic [vic_pkg::NUM_TMRM-1:0] timer0_match,
	input  wire logic [vic_pkg::NUM_TMRM-1:0] timer1_match,
	input  wire logic                        ser0_receive_line_status_flag,
	input  wire logic                        ser0_transmit_holding_empty_flag,
	input  wire logic                        ser0_receive_data_available_flag,
	input  wire logic                        ser0_character_timeout_flag,
	input  wire logic                        ser1_receive_line_status_flag,
	input  wire logic                        ser1_transmit_holding_empty_flag,
	input  wire logic                        ser1_receive_data_available_flag,
	input  wire logic                        ser1_character_timeout_flag,
	input  wire logic                        ser1_modem_status_flag,
	input  wire logic [vic_pkg::NUM_PWMM-1:0] pwm_match,
	input  wire logic                        twi_state_flag,
	input  wire logic                        spi0_serial_transfer_done_flag,
	input  wire logic                        spi0_serial_mode_fault_flag,
	input  wire logic                        spi1_serial_transfer_done_flag,
	input  wire logic                        spi1_serial_mode_fault_flag,
	input  wire logic                        sync_port_transmit_flag,
	input  wire logic                        sync_port_receive_flag,
	input  wire logic                        sync_port_rx_timeout_flag,
	input  wire logic                        sync_port_overrun_flag,
	input  wire logic                        multiplier_lock_flag,
	input  wire logic                        clock_count_increment_flag,
	input  wire logic                        clock_alarm_flag,
	input  wire logic [vic_pkg::NUM_EXT-1:0] external_request,
	input  wire logic                        adc_request,
	output logic                             irq_reg,
	output logic                             event_irq_reg
);
	localparam int NCH = vic_pkg::NUM_CHAN;
	localparam int DW  = vic_pkg::DATA_W;

	// Elaboration check: slot decode only serves up to the package slot count
	if (NSLOT < 1 || NSLOT > vic_pkg::NUM_SLOT) begin : g_bad_nslot
		$error("vic_top: slot count out of range");
	end

	// Channel mapping, one combined line per peripheral
	logic [NCH-1:0] raw;
	logic [NCH-1:0] soft_reg;
	logic [NCH-1:0] enable_reg;
	logic [DW-1:0]  defaddr_reg;

	always_comb begin
		raw                        = '0;
		raw[vic_pkg::CH_WDOG]      = watchdog_flag;
		raw[vic_pkg::CH_SOFT]      = 1'b0;
		raw[vic_pkg::CH_DBGRX]     = debug_comm_receive;
		raw[vic_pkg::CH_DBGTX]     = debug_comm_transmit;
		raw[vic_pkg::CH_TMR0]      = |timer0_match;
		raw[vic_pkg::CH_TMR1]      = |timer1_match;
		raw[vic_pkg::CH_SER0]      = ser0_receive_line_status_flag | ser0_transmit_holding_empty_flag
			| ser0_receive_data_available_flag | ser0_character_timeout_flag;
		raw[vic_pkg::CH_SER1]      = ser1_receive_line_status_flag | ser1_transmit_holding_empty_flag
			| ser1_receive_data_available_flag | ser1_character_timeout_flag
			| ser1_modem_status_flag;
		raw[vic_pkg::CH_PWM]       = |pwm_match;
		raw[vic_pkg::CH_TWI]       = twi_state_flag;
		raw[vic_pkg::CH_SPI0]      = spi0_serial_transfer_done_flag | spi0_serial_mode_fault_flag;
		raw[vic_pkg::CH_SPI1]      = spi1_serial_transfer_done_flag | spi1_serial_mode_fault_flag
			| sync_port_transmit_flag | sync_port_receive_flag
			| sync_port_rx_timeout_flag | sync_port_overrun_flag;
		raw[vic_pkg::CH_PLL]       = multiplier_lock_flag;
		raw[vic_pkg::CH_RTC]       = clock_count_increment_flag | clock_alarm_flag;
		raw[vic_pkg::CH_EXT0 +: vic_pkg::NUM_EXT] = external_request;
		raw[vic_pkg::CH_ADC]       = adc_request;
	end

	// Levels pass straight through; only soft_reg is latched, the source clears its flag
	wire logic [NCH-1:0] raw_all = raw | soft_reg;
	wire logic [NCH-1:0] active  = raw_all & enable_reg;

	// Register decode
	wire logic       is_slot_addr = (reg_addr & vic_pkg::SLOT_MASK) == vic_pkg::OFF_VADDR0;
	wire logic       is_slot_ctrl = (reg_addr & vic_pkg::SLOT_MASK) == vic_pkg::OFF_VCTRL0;
	wire logic [3:0] slot_sel     = reg_addr[5:2];
	wire logic       wr_enable    = reg_wr && reg_addr == vic_pkg::OFF_ENABLE;
	wire logic       wr_soft      = reg_wr && reg_addr == vic_pkg::OFF_SOFT;
	wire logic       wr_softclr   = reg_wr && reg_addr == vic_pkg::OFF_SOFTCLR;
	wire logic       wr_defaddr   = reg_wr && reg_addr == vic_pkg::OFF_DEFADDR;
	wire logic       wr_evena     = reg_wr && reg_addr == vic_pkg::OFF_EVENA;
	wire logic       wr_evclr     = reg_wr && reg_addr == vic_pkg::OFF_EVCLR;

	// Priority slots
	logic [NSLOT-1:0]    slot_hit;
	logic [DW-1:0]       slot_addr [NSLOT];
	logic [5:0]          slot_ctrl [NSLOT];
	logic [NCH-1:0]      slot_mask [NSLOT];
	logic [NCH-1:0]      vect_chans;

	for (genvar s = 0; s < NSLOT; s++) begin : g_slot
		vic_slot #(
			.NCH(NCH)
		) u_slot (
			.sys_clk  (sys_clk),
			.resetn   (resetn),
			.clk_en   (clk_en),
			.wr_addr  (reg_wr && is_slot_addr && slot_sel == 4'(s)),
			.wr_ctrl  (reg_wr && is_slot_ctrl && slot_sel == 4'(s)),
			.wdata    (reg_wdata),
			.active   (active),
			.vaddr_reg(slot_addr[s]),
			.vctrl_reg(slot_ctrl[s]),
			.hit      (slot_hit[s])
		);
		assign slot_mask[s] = slot_ctrl[s][vic_pkg::VCTRL_EN_BIT]
			? (NCH'(1) << slot_ctrl[s][vic_pkg::CHAN_W-1:0]) : '0;
	end

	always_comb begin
		vect_chans = '0;
		for (int s = 0; s < NSLOT; s++)
			vect_chans = vect_chans | slot_mask[s];
	end

	logic                      vect_any;
	logic [vic_pkg::SLOT_W-1:0] vect_idx;

	vic_prio #(
		.N (NSLOT),
		.IW(vic_pkg::SLOT_W)
	) u_prio (
		.req(slot_hit),
		.any(vect_any),
		.idx(vect_idx)
	);

	// Non-vectored active lines are those not claimed by any enabled slot, counted even while a vectored line is pending
	wire logic [NCH-1:0] nvec_active = active & ~vect_chans;
	wire logic           nvec_any    = |nvec_active;
	wire logic [DW-1:0]  vector_out  = vect_any ? slot_addr[vect_idx] : defaddr_reg;
	wire logic           irq_next    = vect_any | nvec_any;

	// Events: vectored or non-vectored request became pending
	logic                        vect_any_d;
	logic                        nvec_any_d;
	logic [vic_pkg::NUM_EV-1:0]  evstat_reg;
	logic [vic_pkg::NUM_EV-1:0]  evena_reg;
	wire logic [vic_pkg::NUM_EV-1:0] ev_set = {nvec_any & ~nvec_any_d, vect_any & ~vect_any_d};
	wire logic [vic_pkg::NUM_EV-1:0] ev_clr = wr_evclr ? reg_wdata[vic_pkg::NUM_EV-1:0] : '0;
	// Set wins over a clear in the same cycle
	wire logic [vic_pkg::NUM_EV-1:0] evstat_next = (evstat_reg & ~ev_clr) | ev_set;

	wire logic [DW-1:0] slot_rd = is_slot_addr ? slot_addr[slot_sel] : DW'(slot_ctrl[slot_sel]);
	wire logic          slot_ok = (is_slot_addr || is_slot_ctrl) && 32'(slot_sel) < NSLOT;

	logic [DW-1:0] rd_mux;
	always_comb begin
		unique case (reg_addr)
			vic_pkg::OFF_VECT:    rd_mux = vector_out;
			vic_pkg::OFF_RAW:     rd_mux = DW'(raw_all);
			vic_pkg::OFF_ENABLE:  rd_mux = DW'(enable_reg);
			vic_pkg::OFF_VENA:    rd_mux = DW'(vect_chans);
			vic_pkg::OFF_SOFT:    rd_mux = DW'(soft_reg);
			vic_pkg::OFF_DEFADDR: rd_mux = defaddr_reg;
			vic_pkg::OFF_IRQSTAT: rd_mux = DW'(active);
			vic_pkg::OFF_NVSTAT:  rd_mux = DW'(nvec_active);
			vic_pkg::OFF_EVSTAT:  rd_mux = DW'(evstat_reg);
			vic_pkg::OFF_EVENA:   rd_mux = DW'(evena_reg);
			default:              rd_mux = slot_ok ? slot_rd : '0;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			soft_reg      <= '0;
			enable_reg    <= '0;
			defaddr_reg   <= vic_pkg::DEFADDR_RESET;
			evstat_reg    <= '0;
			evena_reg     <= '0;
			vect_any_d    <= 1'b0;
			nvec_any_d    <= 1'b0;
			irq_reg       <= 1'b0;
			event_irq_reg <= 1'b0;
			reg_rdata     <= '0;
		end else if (clk_en) begin
			if (wr_soft)
				soft_reg <= soft_reg | reg_wdata[NCH-1:0];
			else if (wr_softclr)
				soft_reg <= soft_reg & ~reg_wdata[NCH-1:0];
			if (wr_enable)
				enable_reg <= reg_wdata[NCH-1:0];
			if (wr_defaddr)
				defaddr_reg <= reg_wdata;
			if (wr_evena)
				evena_reg <= reg_wdata[vic_pkg::NUM_EV-1:0];
			evstat_reg    <= evstat_next;
			vect_any_d    <= vect_any;
			nvec_any_d    <= nvec_any;
			irq_reg       <= irq_next;
			event_irq_reg <= |(evstat_next & evena_reg);
			reg_rdata     <= reg_rd ? rd_mux : '0;
		end
	end
endmodule

// ---- testbench/vectored_irq_combiner_tb.sv ----
`timescale 1ns/1ps
// Self-checking bench for the interrupt unit
module vectored_irq_combiner_tb;
	logic        sys_clk;
	logic        resetn;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic        clk_en;
	logic [31:0] reg_rdata;
	logic [43:0] src;
	logic        irq_reg;
	logic        event_irq_reg;
	int          entries;
	int          err_count;
	int          compares;
	int          cycles;
	int          i;
	// Clock enable dropped once near the end to prove the freeze
	vic_top DUT (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .watchdog_flag(src[0]),
		.debug_comm_receive(src[1]), .debug_comm_transmit(src[2]), .timer0_match(src[6:3]), .timer1_match(src[10:7]),
		.ser0_receive_line_status_flag(src[11]), .ser0_transmit_holding_empty_flag(src[12]),
		.ser0_receive_data_available_flag(src[13]), .ser0_character_timeout_flag(src[14]),
		.ser1_receive_line_status_flag(src[15]), .ser1_transmit_holding_empty_flag(src[16]),
		.ser1_receive_data_available_flag(src[17]), .ser1_character_timeout_flag(src[18]),
		.ser1_modem_status_flag(src[19]), .pwm_match(src[26:20]), .twi_state_flag(src[27]),
		.spi0_serial_transfer_done_flag(src[28]), .spi0_serial_mode_fault_flag(src[29]),
		.spi1_serial_transfer_done_flag(src[30]), .spi1_serial_mode_fault_flag(src[31]),
		.sync_port_transmit_flag(src[32]), .sync_port_receive_flag(src[33]), .sync_port_rx_timeout_flag(src[34]),
		.sync_port_overrun_flag(src[35]), .multiplier_lock_flag(src[36]), .clock_count_increment_flag(src[37]),
		.clock_alarm_flag(src[38]), .external_request(src[42:39]), .adc_request(src[43]), .irq_reg(irq_reg),
		.event_irq_reg(event_irq_reg));
	vir_core_model u_core (.sys_clk(sys_clk), .resetn(resetn), .irq_reg(irq_reg), .entries(entries));
	function automatic int chan(input int b);
		if (b == 0) return 0;
		if (b < 3) return b + 1;
		if (b < 11) return 4 + (b - 3) / 4;
		if (b < 15) return 6;
		if (b < 20) return 7;
		if (b < 27) return 8;
		if (b == 27) return 9;
		if (b < 30) return 10;
		if (b < 36) return 11;
		if (b == 36) return 12;
		if (b < 39) return 13;
		if (b < 43) return b - 25;
		return 18;
	endfunction
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= d;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge sys_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp);
	endtask
	// Two edges let the level reach status and the registered irq
	task automatic drive(input logic [43:0] v);
		@(posedge sys_clk);
		src <= v;
		repeat (2) @(posedge sys_clk);
		#1;
	endtask
	task automatic wrap_up;
		if (err_count == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cycles++;
		if (cycles == 3000) begin
			err_count++;
			wrap_up();
		end
	end
	initial begin
		{resetn, reg_wr, reg_rd, reg_addr, reg_wdata, src} = '0;
		{err_count, compares, cycles} = '0;
		clk_en = 1'b1;
		repeat (4) @(posedge sys_clk);
		resetn <= 1'b1;
		rd(vic_pkg::OFF_ENABLE, 32'h0);
		rd(vic_pkg::OFF_VECT, vic_pkg::DEFADDR_RESET);
		wr(8'h3c, 32'hffff_ffff);
		rd(8'h3c, 32'h0);
		wr(vic_pkg::OFF_ENABLE, 32'h0007_ffff);
		for (i = 0; i < 44; i++) begin
			drive(44'h1 << i);
			check({31'h0, irq_reg}, 32'h1);
			rd(vic_pkg::OFF_RAW, 32'h1 << chan(i));
			rd(vic_pkg::OFF_IRQSTAT, 32'h1 << chan(i));
		end
		drive(44'h0);
		check({31'h0, irq_reg}, 32'h0);
		wr(vic_pkg::OFF_SOFT, 32'h2);
		rd(vic_pkg::OFF_RAW, 32'h2);
		check({31'h0, irq_reg}, 32'h1);
		wr(vic_pkg::OFF_SOFTCLR, 32'h2);
		rd(vic_pkg::OFF_RAW, 32'h0);
		wr(vic_pkg::OFF_DEFADDR, 32'h0000_1230);
		wr(vic_pkg::OFF_VADDR0, 32'h0000_0100);
		wr(vic_pkg::OFF_VCTRL0, 32'h0000_002e);
		wr(vic_pkg::OFF_VADDR0 + 8'h04, 32'h0000_0200);
		wr(vic_pkg::OFF_VCTRL0 + 8'h04, 32'h0000_0024);
		drive(44'h1);
		rd(vic_pkg::OFF_VECT, 32'h0000_1230);
		rd(vic_pkg::OFF_NVSTAT, 32'h1);
		drive(44'h9 | (44'h1 << 39));
		rd(vic_pkg::OFF_VECT, 32'h0000_0100);
		rd(vic_pkg::OFF_VECT, 32'h0000_0100);
		drive(44'h9);
		rd(vic_pkg::OFF_VECT, 32'h0000_0200);
		rd(vic_pkg::OFF_NVSTAT, 32'h1);
		drive(44'h0);
		wr(vic_pkg::OFF_EVCLR, 32'h3);
		rd(vic_pkg::OFF_EVSTAT, 32'h0);
		drive(44'h8);
		rd(vic_pkg::OFF_EVSTAT, 32'h1);
		check({31'h0, event_irq_reg}, 32'h0);
		wr(vic_pkg::OFF_EVENA, 32'h1);
		drive(44'h8);
		check({31'h0, event_irq_reg}, 32'h1);
		wr(vic_pkg::OFF_EVCLR, 32'h1);
		drive(44'h8);
		check({31'h0, event_irq_reg}, 32'h0);
		check({31'h0, entries != 0}, 32'h1);
		@(posedge sys_clk);
		clk_en <= 1'b0;
		src    <= 44'h0;
		repeat (2) @(posedge sys_clk);
		#1;
		check({31'h0, irq_reg}, 32'h1);
		@(posedge sys_clk);
		clk_en <= 1'b1;
		repeat (2) @(posedge sys_clk);
		#1;
		check({31'h0, irq_reg}, 32'h0);
		wrap_up();
	end
endmodule

// ---- testbench/vir_chk_sva.sv ----
`timescale 1ns/1ps
// Port-level assertions for the interrupt unit
module vir_chk (
	input wire logic        sys_clk,
	input wire logic        resetn,
	input wire logic        clk_en,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        watchdog_flag,
	input wire logic [3:0]  external_request,
	input wire logic        irq_reg,
	input wire logic        event_irq_reg
);
	logic [18:0] en_reg;
	logic [31:0] def_reg;
	logic [1:0]  ev_en_reg;
	wire         wr_go   = clk_en && reg_wr;
	wire         rd_go   = clk_en && reg_rd;
	wire         rd_vect = rd_go && reg_addr == vic_pkg::OFF_VECT;
	wire         rd_raw  = rd_go && reg_addr == vic_pkg::OFF_RAW;
	wire         rd_stat = rd_go && reg_addr == vic_pkg::OFF_IRQSTAT;
	// Shadows follow bus writes so reads can be judged without the bodies
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			en_reg    <= '0;
			def_reg   <= vic_pkg::DEFADDR_RESET;
			ev_en_reg <= '0;
		end else if (wr_go) begin
			if (reg_addr == vic_pkg::OFF_ENABLE) en_reg <= reg_wdata[18:0];
			if (reg_addr == vic_pkg::OFF_DEFADDR) def_reg <= reg_wdata;
			if (reg_addr == vic_pkg::OFF_EVENA) ev_en_reg <= reg_wdata[1:0];
		end
	end
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);
	AST_IRQ_IS_ACTIVE_OR: assert property (rd_stat |=> irq_reg == (reg_rdata != '0))
		else $error("irq level differs from active status");
	AST_DEFAULT_NO_ENABLE: assert property (rd_vect && en_reg == '0 |=> reg_rdata == $past(def_reg))
		else $error("vector read missed default address");
	AST_DEFADDR_BACK: assert property (rd_go && reg_addr == vic_pkg::OFF_DEFADDR |=> reg_rdata == $past(def_reg))
		else $error("default address readback wrong");
	AST_ENABLE_BACK: assert property (rd_go && reg_addr == vic_pkg::OFF_ENABLE |=> reg_rdata == {13'h0, $past(en_reg)})
		else $error("enable readback wrong");
	AST_WDOG_ON_CH0: assert property (rd_raw && watchdog_flag |=> reg_rdata[0])
		else $error("watchdog not on channel 0");
	AST_EXT_ON_CH14: assert property (rd_raw |=> (reg_rdata[17:14] & $past(external_request)) == $past(external_request))
		else $error("external requests not on channels 14 to 17");
	AST_RAW_UPPER_ZERO: assert property (rd_raw |=> reg_rdata[31:19] == 13'h0)
		else $error("raw bits above channel 18 set");
	AST_WDOG_LEVEL_IRQ: assert property (watchdog_flag && en_reg[0] && clk_en |=> irq_reg)
		else $error("level request did not hold irq");
	AST_RDATA_ONE_CYCLE: assert property (clk_en && !reg_rd |=> reg_rdata == '0)
		else $error("read data outside its cycle");
	AST_EVENT_MASKED: assert property (ev_en_reg == 2'h0 && $past(ev_en_reg) == 2'h0 |-> !event_irq_reg)
		else $error("event irq while masked");
endmodule
bind vic_top vir_chk u_chk (.sys_clk(sys_clk), .resetn(resetn), .clk_en(clk_en), .reg_addr(reg_addr),
	.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .watchdog_flag(watchdog_flag),
	.external_request(external_request), .irq_reg(irq_reg), .event_irq_reg(event_irq_reg));

// ---- testbench/vir_core_model.sv ----
`timescale 1ns/1ps
// Processor core model: counts entries into interrupt service
module vir_core_model (
	input  wire logic sys_clk,
	input  wire logic resetn,
	input  wire logic irq_reg,
	output int        entries
);
	logic irq_seen_reg;
	// Entry only on a rising level, since the core masks while servicing
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			irq_seen_reg <= 1'b0;
			entries      <= 0;
		end else begin
			irq_seen_reg <= irq_reg;
			if (irq_reg && !irq_seen_reg) entries <= entries + 1;
		end
	end
endmodule
